// ===== drive_data_map.sv
/*
 slave-side data map of the drive's serial fieldbus: coils and holding registers
 behind zero-based telegram addresses, with command, reference, status, feedback,
 storage select, fault, error-address, index and parameter-window access.
 assumes a telegram decoder on mclk that presents one access per pulse and takes
 the answer on the following cycle; the parameter database answers combinationally.
*/
// Contract
// - each coil is one bit; each holding register is a 16-bit word.
// - coil number N sits at telegram address N minus one.
// - holding register 40001 sits at address zero; 40108 at 0x006b.
// - coils 1..16 hold the command word written by the master.
// - coils 17..32 hold the 16-bit speed reference, full span plus minus 200 percent.
// - coils 33..48 show status; 49..64 show frequency or feedback by loop mode.
// - coil 65 picks volatile only (0) or volatile plus nonvolatile (1) storage.
// - command bits 1,2 preset reference, 14 set-up low, 16 reverse, 15 unused.
// - zero in bits 3,4,5,7 requests brake, coast, quick, ramp stop; 6 freezes.
// - status 33..36 ready, ready, safety, alarm; 40..42,44 warn, ref, auto, run.
// - addresses 0..2 legacy reserved, 3 and 4 free, no defined access.
// - address 5 is read/write configuration for the tcp variant, no serial function.
// - address 6 reads the most recent fault code from the parameter database.
// - address 7 reads the address of the most recent access error.
// - address 8 is a read/write array sub-index pointer for parameter accesses.
// - parameter windows start at ten times the number, access per parameter.
// - coils above 65 are reserved and carry no function.
// - an address outside the map answers exception code 2.
module drive_data_map
    import drive_map_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    // telegram access, one request per pulse
    input wire logic acc_valid,
    input wire logic acc_is_coil,
    input wire logic acc_write,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    output logic acc_done_ff,
    output logic [15:0] acc_rdata_ff,
    output logic [7:0] acc_exc_ff,
    // drive-side state shown to the master
    input wire logic closed_loop,
    input wire logic [15:0] out_frequency,
    input wire logic [15:0] feedback_value,
    input wire logic ctrl_ready,
    input wire logic drive_ready,
    input wire logic safety_closed,
    input wire logic alarm,
    input wire logic warning,
    input wire logic at_reference,
    input wire logic auto_mode,
    input wire logic in_freq_range,
    input wire logic running,
    input wire logic voltage_warning,
    input wire logic current_limit,
    input wire logic thermal_warning,
    // parameter database port
    output logic par_req,
    output logic par_write,
    output logic [15:0] par_number,
    output logic [15:0] par_offset,
    output logic [15:0] par_subindex,
    output logic [15:0] par_wdata,
    input wire logic [15:0] par_rdata,
    input wire logic [1:0] par_access,
    input wire logic par_fault_valid,
    input wire logic [15:0] par_fault_code,
    // decoded command outputs
    output logic [15:0] drive_command_word,
    output logic [15:0] speed_reference,
    output logic store_nonvolatile,
    output logic [1:0] preset_ref_sel,
    output logic setup_sel_lo,
    output logic reverse_req,
    output logic dc_brake_req,
    output logic coast_req,
    output logic quick_stop_req,
    output logic start_req,
    output logic ramp_stop_req,
    output logic freeze_req,
    output logic fault_reset_req,
    output logic jog_req,
    output logic ramp2_sel,
    output logic data_valid,
    output logic relay1_on,
    output logic relay2_on
);
    logic [15:0] cmd_ff;
    logic [15:0] ref_ff;
    logic store_ff;
    logic [15:0] cfg_ff;
    logic [15:0] fault_ff;
    logic [15:0] err_addr_ff;
    logic [15:0] idx_ff;
    logic [15:0] state_word;
    logic [15:0] fbk_word;
    logic [15:0] coil_word;
    logic [3:0] coil_bit;
    logic coil_in_map;
    logic coil_writable;
    logic reg_in_param;
    logic reg_in_map;
    logic reg_writable;
    logic [15:0] nxt_rdata;
    logic bad_access;
    access_t par_kind;

    // status word assembled from drive state, unused bits zero
    always_comb
    begin
        state_word = 16'h0000;
        state_word[sts_ctrl_ready] = ctrl_ready;
        state_word[sts_drive_ready] = drive_ready;
        state_word[sts_safety] = safety_closed;
        state_word[sts_alarm] = alarm;
        state_word[sts_warning] = warning;
        state_word[sts_at_ref] = at_reference;
        state_word[sts_auto] = auto_mode;
        state_word[sts_in_range] = in_freq_range;
        state_word[sts_running] = running;
        state_word[sts_volt_warn] = voltage_warning;
        state_word[sts_cur_limit] = current_limit;
        state_word[sts_therm_warn] = thermal_warning;
    end

    // feedback coils follow the loop mode
    assign fbk_word = closed_loop ? feedback_value : out_frequency;

    // coil decode: address is coil number minus one, 16 coils per word
    assign coil_bit = acc_addr[3:0];
    assign coil_in_map = (acc_addr <= coil_last);
    assign coil_writable = (acc_addr < coil_sts_base) || (acc_addr == coil_store_sel);

    // coil word selected by the address block
    always_comb
    begin
        coil_word = 16'h0000;
        if (acc_addr < coil_ref_base)
        begin
            coil_word = cmd_ff;
        end
        else if (acc_addr < coil_sts_base)
        begin
            coil_word = ref_ff;
        end
        else if (acc_addr < coil_fbk_base)
        begin
            coil_word = state_word;
        end
        else if (acc_addr < coil_store_sel)
        begin
            coil_word = fbk_word;
        end
        else if (acc_addr == coil_store_sel)
        begin
            coil_word = {15'h0000, store_ff};
        end
    end

    // parameter window mapping: register address plus one is ten times the number plus the offset
    assign reg_in_param = (acc_addr >= param_first);
    assign par_kind = access_t'(par_access);
    assign par_number = 16'((32'(acc_addr) + 32'd1) / 32'(param_stride));
    assign par_offset = 16'((32'(acc_addr) + 32'd1) % 32'(param_stride));
    assign par_subindex = idx_ff;
    assign par_wdata = acc_wdata;
    assign par_req = acc_valid && !acc_is_coil && reg_in_param;
    assign par_write = par_req && acc_write && (par_kind == acc_rw);

    // holding-register decode; legacy and free slots have no defined access
    always_comb
    begin
        reg_in_map = 1'b0;
        reg_writable = 1'b0;
        nxt_rdata = 16'h0000;
        if (acc_is_coil)
        begin
            reg_in_map = coil_in_map;
            reg_writable = coil_writable;
            nxt_rdata = {15'h0000, coil_word[coil_bit]};
        end
        else if (acc_addr <= reg_free_last)
        begin
            reg_in_map = 1'b0;
        end
        else if (acc_addr == network_variant_config)
        begin
            reg_in_map = 1'b1;
            reg_writable = 1'b1;
            nxt_rdata = cfg_ff;
        end
        else if (acc_addr == recent_fault_code)
        begin
            reg_in_map = 1'b1;
            nxt_rdata = fault_ff;
        end
        else if (acc_addr == recent_error_address)
        begin
            reg_in_map = 1'b1;
            nxt_rdata = err_addr_ff;
        end
        else if (acc_addr == array_subindex_pointer)
        begin
            reg_in_map = 1'b1;
            reg_writable = 1'b1;
            nxt_rdata = idx_ff;
        end
        else if (reg_in_param)
        begin
            reg_in_map = (par_kind != acc_none);
            reg_writable = (par_kind == acc_rw);
            nxt_rdata = par_rdata;
        end
    end

    // out of map, or a write to a read-only place, is an access error
    assign bad_access = !reg_in_map || (acc_write && !reg_writable);

    // answer registers, one cycle after the request
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            acc_done_ff <= 1'b0;
            acc_rdata_ff <= 16'h0000;
            acc_exc_ff <= exc_none;
        end
        else
        begin
            acc_done_ff <= acc_valid;
            if (acc_valid)
            begin
                acc_rdata_ff <= (bad_access || acc_write) ? 16'h0000 : nxt_rdata;
                acc_exc_ff <= !reg_in_map ? exc_illegal_address : exc_none;
            end
        end
    end

    // command, reference and storage coils; writable only in their ranges
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cmd_ff <= cmd_reset_value;
            ref_ff <= ref_reset_value;
            store_ff <= 1'b0;
        end
        else if (acc_valid && acc_is_coil && acc_write && coil_in_map)
        begin
            if (acc_addr < coil_ref_base)
            begin
                cmd_ff[coil_bit] <= acc_wdata[0];
            end
            else if (acc_addr < coil_sts_base)
            begin
                ref_ff[coil_bit] <= acc_wdata[0];
            end
            else if (acc_addr == coil_store_sel)
            begin
                store_ff <= acc_wdata[0];
            end
        end
    end

    // configuration and index registers
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            cfg_ff <= cfg_reset_value;
            idx_ff <= idx_reset_value;
        end
        else if (acc_valid && !acc_is_coil && acc_write)
        begin
            if (acc_addr == network_variant_config)
            begin
                cfg_ff <= acc_wdata;
            end
            else if (acc_addr == array_subindex_pointer)
            begin
                idx_ff <= acc_wdata;
            end
        end
    end

    // latest fault code from the parameter database
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            fault_ff <= err_reset_value;
        end
        else if (par_fault_valid)
        begin
            fault_ff <= par_fault_code;
        end
    end

    // address of the latest failed access
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            err_addr_ff <= err_reset_value;
        end
        else if (acc_valid && bad_access)
        begin
            err_addr_ff <= acc_addr;
        end
    end

    // command word decode towards the drive
    assign drive_command_word = cmd_ff;
    assign speed_reference = ref_ff;
    assign store_nonvolatile = store_ff;
    assign preset_ref_sel = {cmd_ff[cmd_preset_hi], cmd_ff[cmd_preset_lo]};
    assign setup_sel_lo = cmd_ff[cmd_setup_lo];
    assign reverse_req = cmd_ff[cmd_reverse];
    assign dc_brake_req = !cmd_ff[cmd_dc_brake_n];
    assign coast_req = !cmd_ff[cmd_coast_n];
    assign quick_stop_req = !cmd_ff[cmd_quick_n];
    assign freeze_req = !cmd_ff[cmd_freeze_n];
    assign start_req = cmd_ff[cmd_start];
    assign ramp_stop_req = !cmd_ff[cmd_start];
    assign fault_reset_req = cmd_ff[cmd_reset];
    assign jog_req = cmd_ff[cmd_jog];
    assign ramp2_sel = cmd_ff[cmd_ramp2];
    assign data_valid = cmd_ff[cmd_data_valid];
    assign relay1_on = cmd_ff[cmd_relay1];
    assign relay2_on = cmd_ff[cmd_relay2];
endmodule : drive_data_map

// ===== drive_data_map_asserts.sv
/*
 port checker for the drive data map: answer timing, exceptions, coil writes, decode.
 assumes it is bound onto drive_data_map; mclk clocks it, reset is synchronous high.
*/
module drive_data_map_asserts
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic acc_valid,
    input wire logic acc_is_coil,
    input wire logic acc_write,
    input wire logic [15:0] acc_addr,
    input wire logic [15:0] acc_wdata,
    input wire logic acc_done_ff,
    input wire logic [7:0] acc_exc_ff,
    input wire logic [15:0] drive_command_word,
    input wire logic [15:0] speed_reference,
    input wire logic store_nonvolatile,
    input wire logic dc_brake_req,
    input wire logic start_req,
    input wire logic ramp_stop_req,
    input wire logic par_req,
    input wire logic [15:0] par_number,
    input wire logic [15:0] par_offset
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    // every access is answered exactly one cycle later, and nothing else is
    done_pulse_a: assert property (acc_valid |=> acc_done_ff)
        else $error("access left unanswered");
    no_spurious_a: assert property (!acc_valid |=> !acc_done_ff)
        else $error("answer without access");
    // coil addresses past the storage select are outside the map
    coil_range_a: assert property (acc_valid && acc_is_coil && acc_addr > 16'h0040 |=> acc_exc_ff == 8'h02)
        else $error("reserved coil not refused");
    legacy_regs_a: assert property (acc_valid && !acc_is_coil && !acc_write && acc_addr <= 16'h0004
        |=> acc_exc_ff == 8'h02) else $error("legacy register read not refused");
    // coil writes land in the bit that the zero-based address names
    cmd_coil_a: assert property (acc_valid && acc_is_coil && acc_write && acc_addr < 16'h0010
        |=> drive_command_word[$past(acc_addr[3:0])] == $past(acc_wdata[0])) else $error("command coil lost");
    ref_coil_a: assert property (acc_valid && acc_is_coil && acc_write && acc_addr[15:4] == 12'h001
        |=> speed_reference[$past(acc_addr[3:0])] == $past(acc_wdata[0])) else $error("reference coil lost");
    store_sel_a: assert property (acc_valid && acc_is_coil && acc_write && acc_addr == 16'h0040
        |=> store_nonvolatile == $past(acc_wdata[0])) else $error("storage select lost");
    status_wr_a: assert property (acc_valid && acc_is_coil && acc_write && acc_addr[15:5] == 11'h001
        |=> $stable(drive_command_word) && $stable(speed_reference)) else $error("status write changed state");
    stop_decode_a: assert property ((dc_brake_req == !drive_command_word[2]) &&
        (start_req == drive_command_word[6]) && (ramp_stop_req == !start_req)) else $error("stop decode wrong");
    // parameter window: request exactly on register addresses from 9, number is (addr+1)/10
    par_decode_a: assert property ((par_req == (acc_valid && !acc_is_coil && acc_addr >= 16'h0009)) &&
        (!par_req || (par_number == ({1'b0, acc_addr} + 17'h00001) / 17'h0000a && par_offset ==
        ({1'b0, acc_addr} + 17'h00001) % 17'h0000a))) else $error("parameter window decode wrong");
endmodule : drive_data_map_asserts

bind drive_data_map drive_data_map_asserts chk (.mclk(mclk), .reset(reset), .acc_valid(acc_valid),
    .acc_is_coil(acc_is_coil), .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done_ff(acc_done_ff), .acc_exc_ff(acc_exc_ff), .drive_command_word(drive_command_word),
    .speed_reference(speed_reference), .store_nonvolatile(store_nonvolatile), .dc_brake_req(dc_brake_req),
    .start_req(start_req), .ramp_stop_req(ramp_stop_req), .par_req(par_req), .par_number(par_number),
    .par_offset(par_offset));

// ===== drive_map_pkg.sv
/*
 the package holds the coil and holding-register layout of the drive data map:
 zero-based addresses, field positions, reset values and access codes.
 assumes it is compiled before the map module that imports it.
*/
package drive_map_pkg;
    // coil addresses (zero-based: coil number minus one)
    localparam logic [15:0] coil_cmd_base = 16'h0000;    // coils 1..16
    localparam logic [15:0] coil_ref_base = 16'h0010;    // coils 17..32
    localparam logic [15:0] coil_sts_base = 16'h0020;    // coils 33..48
    localparam logic [15:0] coil_fbk_base = 16'h0030;    // coils 49..64
    localparam logic [15:0] coil_store_sel = 16'h0040;   // coil 65
    localparam logic [15:0] coil_last = 16'h0040;
    // holding-register addresses (zero-based: register number minus one)
    localparam logic [15:0] reg_legacy_last = 16'h0002;
    localparam logic [15:0] reg_free_last = 16'h0004;
    localparam logic [15:0] network_variant_config = 16'h0005;
    localparam logic [15:0] recent_fault_code = 16'h0006;
    localparam logic [15:0] recent_error_address = 16'h0007;
    localparam logic [15:0] array_subindex_pointer = 16'h0008;
    localparam logic [15:0] display_language_param = 16'h0009;
    localparam logic [15:0] speed_unit_param = 16'h0013;
    localparam logic [15:0] regional_settings_param = 16'h001d;
    // parameter windows: start at ten times the parameter number
    localparam logic [15:0] param_stride = 16'h000a;
    localparam logic [15:0] param_first = 16'h0009;
    localparam logic [15:0] param_last = 16'hffff;
    localparam logic [15:0] param_window_bytes = 16'h0014;
    // command word field positions (coil number minus one)
    localparam int cmd_preset_lo = 0;
    localparam int cmd_preset_hi = 1;
    localparam int cmd_dc_brake_n = 2;
    localparam int cmd_coast_n = 3;
    localparam int cmd_quick_n = 4;
    localparam int cmd_freeze_n = 5;
    localparam int cmd_start = 6;
    localparam int cmd_reset = 7;
    localparam int cmd_jog = 8;
    localparam int cmd_ramp2 = 9;
    localparam int cmd_data_valid = 10;
    localparam int cmd_relay1 = 11;
    localparam int cmd_relay2 = 12;
    localparam int cmd_setup_lo = 13;
    localparam int cmd_reverse = 15;
    // status word field positions (coil number minus 33)
    localparam int sts_ctrl_ready = 0;
    localparam int sts_drive_ready = 1;
    localparam int sts_safety = 2;
    localparam int sts_alarm = 3;
    localparam int sts_warning = 7;
    localparam int sts_at_ref = 8;
    localparam int sts_auto = 9;
    localparam int sts_in_range = 10;
    localparam int sts_running = 11;
    localparam int sts_volt_warn = 13;
    localparam int sts_cur_limit = 14;
    localparam int sts_therm_warn = 15;
    // reset values and exception codes
    localparam logic [15:0] cmd_reset_value = 16'h0000;
    localparam logic [15:0] ref_reset_value = 16'h0000;
    localparam logic [15:0] cfg_reset_value = 16'h0000;
    localparam logic [15:0] idx_reset_value = 16'h0000;
    localparam logic [15:0] err_reset_value = 16'h0000;
    localparam logic [7:0] exc_illegal_address = 8'h02;
    localparam logic [7:0] exc_none = 8'h00;
    // access kinds of a parameter window
    typedef enum logic [1:0]
    {
        acc_none = 2'b00,
        acc_ro = 2'b01,
        acc_rw = 2'b10
    } access_t;
endpackage : drive_map_pkg

// ===== modbus_drive_data_map_tb.sv
/*
 self-checking bench for the drive data map with a parameter database model.
 assumes the map answers one cycle after each access pulse.
*/
module modbus_drive_data_map_tb
    import drive_map_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [15:0] rd; logic [7:0] exc; logic chk;} note_t;
    note_t notes[$];
    note_t cur;
    int err_total = 0;
    int n_checks = 0;
    integer seed = 32'hd07c;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic acc_valid = 1'b0, acc_is_coil = 1'b0, acc_write = 1'b0, closed_loop = 1'b0, fault_fire = 1'b0;
    logic [15:0] acc_addr = 16'h0000, acc_wdata = 16'h0000, out_frequency = 16'h0000, feedback_value = 16'h0000;
    logic [15:0] sts = 16'h0000, fault_value = 16'h0000, c, v, cmd_word, speed_ref;
    wire [15:0] dec;
    logic [15:0] acc_rdata_ff, par_number, par_offset, par_subindex, par_wdata, par_rdata, par_fault_code;
    logic [7:0] acc_exc_ff;
    logic [1:0] par_access;
    logic acc_done_ff, par_req, par_write, par_fault_valid, store_nv;

    drive_data_map uut (.mclk(mclk), .reset(reset), .acc_valid(acc_valid), .acc_is_coil(acc_is_coil),
        .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata), .acc_done_ff(acc_done_ff),
        .acc_rdata_ff(acc_rdata_ff), .acc_exc_ff(acc_exc_ff), .closed_loop(closed_loop),
        .out_frequency(out_frequency), .feedback_value(feedback_value), .ctrl_ready(sts[0]),
        .drive_ready(sts[1]), .safety_closed(sts[2]), .alarm(sts[3]), .warning(sts[7]), .at_reference(sts[8]),
        .auto_mode(sts[9]), .in_freq_range(sts[10]), .running(sts[11]), .voltage_warning(sts[13]),
        .current_limit(sts[14]), .thermal_warning(sts[15]), .par_req(par_req), .par_write(par_write),
        .par_number(par_number), .par_offset(par_offset), .par_subindex(par_subindex), .par_wdata(par_wdata),
        .par_rdata(par_rdata), .par_access(par_access), .par_fault_valid(par_fault_valid),
        .par_fault_code(par_fault_code), .drive_command_word(cmd_word), .speed_reference(speed_ref),
        .store_nonvolatile(store_nv), .preset_ref_sel(dec[1:0]), .dc_brake_req(dec[2]), .coast_req(dec[3]),
        .quick_stop_req(dec[4]), .freeze_req(dec[5]), .start_req(dec[6]), .fault_reset_req(dec[7]),
        .jog_req(dec[8]), .ramp2_sel(dec[9]), .data_valid(dec[10]), .relay1_on(dec[11]), .relay2_on(dec[12]),
        .setup_sel_lo(dec[13]), .ramp_stop_req(dec[14]), .reverse_req(dec[15]));

    param_db_model pdb (.mclk(mclk), .reset(reset), .par_req(par_req), .par_write(par_write),
        .par_number(par_number), .par_offset(par_offset), .par_subindex(par_subindex), .par_wdata(par_wdata),
        .fault_fire(fault_fire), .fault_value(fault_value), .par_rdata(par_rdata), .par_access(par_access),
        .par_fault_valid(par_fault_valid), .par_fault_code(par_fault_code));

    // clock: 40 ns period
    always #20 mclk = ~mclk;

    task final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : check

    // one access per edge, expectation noted for the answer watcher
    task acc(input logic coil, input logic wr, input logic [15:0] a, input logic [15:0] d,
        input logic [15:0] rd, input logic [7:0] exc, input logic chk);
        @(posedge mclk);
        acc_valid <= 1'b1;
        acc_is_coil <= coil;
        acc_write <= wr;
        acc_addr <= a;
        acc_wdata <= d;
        notes.push_back('{rd, exc, chk});
    endtask : acc

    // drop the request and wait, bounded, for all answers
    task idle;
        int n;
        n = 0;
        @(posedge mclk);
        acc_valid <= 1'b0;
        while (notes.size() != 0 && n < 8)
        begin
            @(posedge mclk);
            n++;
        end
        if (notes.size() != 0)
        begin
            err_total++;
            final_report();
        end
    endtask : idle

    // answer watcher: oldest expectation against each answer strobe
    always @(posedge mclk)
    begin
        if (acc_done_ff === 1'b1)
        begin
            if (notes.size() == 0)
                check("unexpected answer", 16'h0000, 16'h0001);
            else
            begin
                cur = notes.pop_front();
                check("exception", {8'h00, cur.exc}, {8'h00, acc_exc_ff});
                if (cur.chk)
                    check("read data", cur.rd, acc_rdata_ff);
                else
                    check("quiet data", 16'h0000, acc_rdata_ff);
            end
        end
    end

    // watchdog
    initial
    begin
        repeat (100000) @(posedge mclk);
        err_total++;
        final_report();
    end

    initial
    begin
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        acc(0, 0, 16'h0008, 0, idx_reset_value, exc_none, 1);
        acc(0, 0, network_variant_config, 0, cfg_reset_value, exc_none, 1);
        idle();
        check("reset decode", 16'h403c, dec);
        // command word: all ones, all zeros, random; written and read back back to back
        for (int k = 0; k < 3; k++)
        begin
            c = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
            for (int b = 0; b < 16; b++)
                acc(1, 1, 16'(b), {15'h0, c[b]}, 0, exc_none, 0);
            for (int b = 0; b < 16; b++)
                acc(1, 0, 16'(b), 0, {15'h0, c[b]}, exc_none, 1);
            idle();
            check("command word", c, cmd_word);
            check("command decode", {c[15], ~c[6], c[13:7], c[6], ~c[5:2], c[1:0]}, dec);
        end
        v = 16'($random(seed));
        for (int b = 0; b < 16; b++)
            acc(1, 1, coil_ref_base + 16'(b), {15'h0, v[b]}, 0, exc_none, 0);
        idle();
        check("speed reference", v, speed_ref);
        // status reads; unused positions read zero; writes there are ignored
        sts <= 16'($random(seed));
        out_frequency <= 16'($random(seed));
        feedback_value <= 16'($random(seed));
        idle();
        for (int b = 0; b < 16; b++)
            acc(1, 0, coil_sts_base + 16'(b), 0, {15'h0, sts[b] & (b != 4 && b != 5 && b != 6 && b != 12)},
                exc_none, 1);
        acc(1, 1, coil_sts_base, 16'h0001, 0, exc_none, 0);
        for (int m = 0; m < 2; m++)
        begin
            idle();
            closed_loop <= m[0];
            v = m[0] ? feedback_value : out_frequency;
            for (int b = 0; b < 16; b++)
                acc(1, 0, coil_fbk_base + 16'(b), 0, {15'h0, v[b]}, exc_none, 1);
        end
        // storage select, then reserved coils
        acc(1, 1, coil_store_sel, 16'h0001, 0, exc_none, 0);
        idle();
        check("store select", 16'h0001, {15'h0, store_nv});
        acc(1, 1, coil_store_sel, 16'h0000, 0, exc_none, 0);
        acc(1, 0, coil_store_sel, 0, 16'h0000, exc_none, 1);
        acc(1, 1, 16'h0041, 16'h0001, 0, exc_illegal_address, 0);
        acc(1, 0, 16'hffff, 0, 0, exc_illegal_address, 0);
        // holding registers
        for (int a = 0; a < 5; a++)
            acc(0, 0, 16'(a), 0, 0, exc_illegal_address, 0);
        v = 16'($random(seed));
        acc(0, 1, network_variant_config, v, 0, exc_none, 0);
        acc(0, 0, network_variant_config, 0, v, exc_none, 1);
        acc(0, 1, array_subindex_pointer, 16'h0002, 0, exc_none, 0);
        acc(0, 0, array_subindex_pointer, 0, 16'h0002, exc_none, 1);
        acc(0, 0, display_language_param, 0, 16'h0801, exc_none, 1);
        acc(0, 1, display_language_param, v, 0, exc_none, 0);
        acc(0, 0, 16'h000a, 0, v ^ 16'h0201, exc_none, 1);
        acc(0, 0, regional_settings_param, 0, 0, exc_illegal_address, 0);
        acc(0, 1, recent_fault_code, v, 0, exc_none, 0);
        acc(0, 1, speed_unit_param, v, 0, exc_none, 0);
        acc(0, 0, speed_unit_param, 0, 16'h0802, exc_none, 1);
        acc(0, 0, recent_error_address, 0, speed_unit_param, exc_none, 1);
        // fault report from the database
        idle();
        fault_value <= 16'($random(seed));
        fault_fire <= 1'b1;
        @(posedge mclk);
        fault_fire <= 1'b0;
        acc(0, 0, recent_fault_code, 0, fault_value, exc_none, 1);
        idle();
        final_report();
    end
endmodule : modbus_drive_data_map_tb

// ===== param_db_model.sv
/*
 behavioural parameter database facing the map: per-parameter access, values, faults.
 assumes the map's combinational request port on mclk; the bench fires faults.
*/
module param_db_model
    import drive_map_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire logic par_req,
    input wire logic par_write,
    input wire logic [15:0] par_number,
    input wire logic [15:0] par_offset,
    input wire logic [15:0] par_subindex,
    input wire logic [15:0] par_wdata,
    input wire logic fault_fire,
    input wire logic [15:0] fault_value,
    output logic [15:0] par_rdata,
    output logic [1:0] par_access,
    output logic par_fault_valid,
    output logic [15:0] par_fault_code
);
    logic [15:0] mem_ff [16];
    // parameter 1 read/write, 2 read only, the rest none
    assign par_access = (par_number == 16'h0001) ? acc_rw : (par_number == 16'h0002) ? acc_ro : acc_none;
    // sub-index and offset mixed in so both show; garbage when not asked
    assign par_rdata = par_req ? mem_ff[par_number[3:0]] ^ {par_subindex[7:0], par_offset[7:0]} : ~mem_ff[0];

    // stores whatever the map asks to write, guarding is the map's job
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
                mem_ff[i] <= 16'h0a00 + 16'(i);
        end
        else if (par_req && par_write)
            mem_ff[par_number[3:0]] <= par_wdata;
    end

    // fault report pulse; code is junk outside the pulse
    always_ff @(posedge mclk)
    begin
        par_fault_valid <= fault_fire;
        par_fault_code <= fault_fire ? fault_value : ~par_fault_code;
    end
endmodule : param_db_model
